/* File: hdl/srfi_pkg.sv */
package srfi_pkg;
  // register offsets on the apb bus (byte addresses, index times four)
  localparam logic [7:0] HV_INTERRUPT_STATUS_IDX = 8'h07; // printed index
  localparam logic [9:0] HV_INTERRUPT_STATUS_ADDR = 10'h01c; // index times four
  localparam logic [9:0] IRQ_MASK_ADDR = 10'h020; // interrupt mask word
  localparam logic [9:0] ROW_COLOR_ATTRIBUTE_ADDR = 10'h024; // row colour attribute byte
  localparam logic [9:0] PALETTE_SEL_ADDR = 10'h028; // per-character palette selection
  localparam logic [9:0] DISPLAY_CTRL_ADDR = 10'h02c; // size and progressive controls
  localparam logic [9:0] ROW_COUNT_ADDR = 10'h030; // live scan line count, read only
  // status field positions
  localparam int ROW_FLAG_BIT = 0;
  localparam int FIELD_FLAG_BIT = 1;
  localparam int ROW_IRQ_EN_BIT = 2;
  localparam int PALETTE_MODE_BIT = 3;
  localparam int FRINGE_RGB_LSB = 4;
  localparam int FRINGE_SEL_BIT = 7;
  // row attribute field positions
  localparam int ATTR_BG_LSB = 0;
  localparam int ATTR_BG_EN_BIT = 3;
  localparam int ATTR_FG_LSB = 4;
  localparam int ATTR_FG_OFF_BIT = 7;
  // display control fields
  localparam int DOUBLE_SIZE_BIT = 0;
  localparam int PROGRESSIVE_BIT = 1;
  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h3;
  // scan lines per text row
  localparam int LINES_NORMAL = 18;
  localparam int LINES_DOUBLE = 36;
endpackage : srfi_pkg

/* File: hdl/srfi_edge_detect.sv */
`timescale 1ns/1ps
// three-stage pin synchroniser with rising edge pulse
module srfi_edge_detect (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic pin_in,
  output logic rise_out
);
  logic [2:0] sync; // stage 0 only feeds stage 1
  logic level; // agreed level
  logic [2:0] next_sync;
  logic next_level;
  logic next_rise;

  // agree once stages 1 and 2 match
  always_comb begin
    next_sync = {sync[1:0], pin_in};
    next_level = (sync[2] == sync[1]) ? sync[2] : level;
    next_rise = next_level & ~level;
  end

  // registers only
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync <= 3'h0;
      level <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      sync <= next_sync;
      level <= next_level;
      rise_out <= next_rise;
    end
  end
endmodule : srfi_edge_detect

/* File: hdl/srfi_color_select.sv */
`timescale 1ns/1ps
// registered colour path: row attribute, palette and fringe choice
module srfi_color_select (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] row_color_attribute_in,
  input wire logic [2:0] palette_sel_in,
  input wire logic palette_mode_in,
  input wire logic fringe_sel_in,
  input wire logic [2:0] fringe_rgb_in,
  input wire logic progressive_in,
  output logic use_palette_out,
  output logic [2:0] fg_rgb_out,
  output logic fg_on_out,
  output logic [2:0] bg_rgb_out,
  output logic bg_on_out,
  output logic [2:0] fringe_color_out,
  output logic fringe_on_out
);
  logic next_use_palette;
  logic next_fg_on;
  logic next_bg_on;
  logic next_fringe_on;
  logic [2:0] next_fringe_color;

  // colour source decision
  always_comb begin
    next_use_palette = palette_mode_in && (palette_sel_in != 3'h0);
    next_fg_on = ~row_color_attribute_in[srfi_pkg::ATTR_FG_OFF_BIT];
    next_bg_on = row_color_attribute_in[srfi_pkg::ATTR_BG_EN_BIT];
    next_fringe_color = fringe_sel_in ? fringe_rgb_in
                      : row_color_attribute_in[srfi_pkg::ATTR_BG_LSB +: 3];
    next_fringe_on = ~progressive_in;
  end

  // registers only
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      use_palette_out <= 1'b0;
      fg_rgb_out <= 3'h0;
      fg_on_out <= 1'b0;
      bg_rgb_out <= 3'h0;
      bg_on_out <= 1'b0;
      fringe_color_out <= 3'h0;
      fringe_on_out <= 1'b0;
    end else begin
      use_palette_out <= next_use_palette;
      fg_rgb_out <= row_color_attribute_in[srfi_pkg::ATTR_FG_LSB +: 3];
      fg_on_out <= next_fg_on;
      bg_rgb_out <= row_color_attribute_in[srfi_pkg::ATTR_BG_LSB +: 3];
      bg_on_out <= next_bg_on;
      fringe_color_out <= next_fringe_color;
      fringe_on_out <= next_fringe_on;
    end
  end
endmodule : srfi_color_select

/* File: hdl/srfi_top.sv */
//Contract
// - field interrupt on vertical sync edge
// - row interrupt on row's first hsync
// - normal rows span 18 lines
// - double size rows span 36 lines
// - status bit 2 enables row interrupt
// - bit 1 field flag, write one clears
// - bit 0 row flag, write one clears
// - later interrupt pends until first cleared
// - palette mode 0 uses row attribute
// - palette mode 1 uses nonzero selection
// - bit 7 picks fringe colour source
// - no fringing in progressive mode
// - attribute bits enable foreground and background
`timescale 1ns/1ps
module srfi_top (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out,
  output logic row_start_out,
  output logic field_start_out,
  output logic use_palette_out,
  output logic [2:0] fg_rgb_out,
  output logic fg_on_out,
  output logic [2:0] bg_rgb_out,
  output logic bg_on_out,
  output logic [2:0] fringe_color_out,
  output logic fringe_on_out
);
  // sync edge pulses
  logic hsync_rise;
  logic vsync_rise;
  // software state
  logic [7:0] status; // hv_interrupt_status
  logic [1:0] mask; // bit0 row, bit1 field
  logic [7:0] row_color_attribute;
  logic [2:0] palette_sel;
  logic [1:0] display_ctrl;
  // row tracking
  // six bits cover the longest row, the double size one
  logic [5:0] line_count; // lines into the current row
  logic in_field; // a field has begun
  // pending event behind the one in service
  logic pend_row;
  logic pend_field;
  // next values
  logic [7:0] next_status;
  logic [1:0] next_mask;
  logic [7:0] next_row_color_attribute;
  logic [2:0] next_palette_sel;
  logic [1:0] next_display_ctrl;
  logic [5:0] next_line_count;
  logic next_in_field;
  logic next_pend_row;
  logic next_pend_field;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_irq;
  logic next_row_start;
  logic next_field_start;
  // decoded bus strobes
  // writes land at the access edge, reads are sampled at the setup edge
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic row_event;
  logic field_event;
  logic [5:0] row_lines;

  // rows span lines according to character size
  function automatic logic [5:0] srfi_row_len(input logic dbl);
    srfi_row_len = dbl ? 6'(srfi_pkg::LINES_DOUBLE) : 6'(srfi_pkg::LINES_NORMAL);
  endfunction : srfi_row_len

  // address decode
  // unmapped words read zero, ignore writes and raise pslverr
  function automatic logic srfi_mapped(input logic [9:0] a);
    srfi_mapped = (a == srfi_pkg::HV_INTERRUPT_STATUS_ADDR) || (a == srfi_pkg::IRQ_MASK_ADDR) ||
                  (a == srfi_pkg::ROW_COLOR_ATTRIBUTE_ADDR) || (a == srfi_pkg::PALETTE_SEL_ADDR) ||
                  (a == srfi_pkg::DISPLAY_CTRL_ADDR) || (a == srfi_pkg::ROW_COUNT_ADDR);
  endfunction : srfi_mapped

  // synchronise horizontal sync
  // three flops per pin, so sync edges are seen three to four clocks late
  srfi_edge_detect u_hsync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .pin_in(hsync_in),
    .rise_out(hsync_rise)
  );

  srfi_edge_detect u_vsync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .pin_in(vsync_in),
    .rise_out(vsync_rise)
  );

  // colour path driven by status bits
  // status bits 7 to 3 only steer colour and play no part in interrupts
  srfi_color_select u_color (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .row_color_attribute_in(row_color_attribute),
    .palette_sel_in(palette_sel),
    .palette_mode_in(status[srfi_pkg::PALETTE_MODE_BIT]),
    .fringe_sel_in(status[srfi_pkg::FRINGE_SEL_BIT]),
    .fringe_rgb_in(status[srfi_pkg::FRINGE_RGB_LSB +: 3]),
    .progressive_in(display_ctrl[srfi_pkg::PROGRESSIVE_BIT]),
    .use_palette_out(use_palette_out),
    .fg_rgb_out(fg_rgb_out),
    .fg_on_out(fg_on_out),
    .bg_rgb_out(bg_rgb_out),
    .bg_on_out(bg_on_out),
    .fringe_color_out(fringe_color_out),
    .fringe_on_out(fringe_on_out)
  );

  // zero wait states: pready is a flop that rises after reset and stays high
  // read data already stands in the access phase, taken at the setup edge
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = srfi_mapped(paddr);
  assign row_lines = srfi_row_len(display_ctrl[srfi_pkg::DOUBLE_SIZE_BIT]);

  // row and field event generation
  // hsync edges before the first vsync are ignored: no row to count from
  // a row is a fixed count of hsync periods; inter-row spacing is not modelled
  always_comb begin
    next_line_count = line_count;
    next_in_field = in_field;
    row_event = 1'b0;
    field_event = 1'b0;
    if (vsync_rise) begin
      field_event = 1'b1;
      next_in_field = 1'b1;
      next_line_count = 6'h00;
    end else if (hsync_rise && in_field) begin
      // first hsync of row starts it
      if (line_count == 6'h00) begin
        row_event = status[srfi_pkg::ROW_IRQ_EN_BIT];
      end
      // wrap after the row's last line
      // the upper guard recovers when the row length shrinks mid row
      if (line_count == row_lines - 6'h01 || line_count >= row_lines) begin
        next_line_count = 6'h00;
      end else begin
        next_line_count = line_count + 6'h01;
      end
    end
  end

  // status, pending and bus writes
  // one pend bit per kind: a repeat of the kind in service merges into its flag
  // pends hold events that came while the other flag was in service, or a row that came beside a new field
  always_comb begin
    next_status = status;
    next_mask = mask;
    next_row_color_attribute = row_color_attribute;
    next_palette_sel = palette_sel;
    next_display_ctrl = display_ctrl;
    next_pend_row = pend_row;
    next_pend_field = pend_field;
    if (wr_en) begin
      unique case (paddr)
        srfi_pkg::HV_INTERRUPT_STATUS_ADDR: begin
          // control fields plain read/write
          next_status[7:2] = pwdata[7:2];
          if (pwdata[srfi_pkg::FIELD_FLAG_BIT]) next_status[srfi_pkg::FIELD_FLAG_BIT] = 1'b0;
          if (pwdata[srfi_pkg::ROW_FLAG_BIT]) next_status[srfi_pkg::ROW_FLAG_BIT] = 1'b0;
        end
        srfi_pkg::IRQ_MASK_ADDR: next_mask = pwdata[1:0];
        srfi_pkg::ROW_COLOR_ATTRIBUTE_ADDR: next_row_color_attribute = pwdata[7:0];
        srfi_pkg::PALETTE_SEL_ADDR: next_palette_sel = pwdata[2:0];
        srfi_pkg::DISPLAY_CTRL_ADDR: next_display_ctrl = pwdata[1:0];
        default: begin
          // unmapped or read-only: no effect
        end
      endcase
    end
    // pended event promoted once both flags clear
    // field pend goes first: a new field restarts the row count anyway
    if (!next_status[1] && !next_status[0]) begin
      if (pend_field) begin
        next_status[srfi_pkg::FIELD_FLAG_BIT] = 1'b1;
        next_pend_field = 1'b0;
      end else if (pend_row) begin
        next_status[srfi_pkg::ROW_FLAG_BIT] = 1'b1;
        next_pend_row = 1'b0;
      end
    end
    // new events: set wins over clear, pend if another in service
    if (field_event) begin
      // pend behind an in-service flag
      // a row flag cleared in this very cycle does not hold the field back
      if (status[srfi_pkg::ROW_FLAG_BIT] && next_status[srfi_pkg::ROW_FLAG_BIT]) begin
        next_pend_field = 1'b1;
      end else begin
        next_status[srfi_pkg::FIELD_FLAG_BIT] = 1'b1;
      end
    end
    // row behind a field in service, or beside a new field, waits in its pend bit
    if (row_event) begin
      if (next_status[srfi_pkg::FIELD_FLAG_BIT] && !field_event) begin
        next_pend_row = 1'b1;
      end else if (field_event) begin
        next_pend_row = 1'b1;
      end else begin
        next_status[srfi_pkg::ROW_FLAG_BIT] = 1'b1;
      end
    end
    // disabling row interrupts drops a pended row
    if (!next_status[srfi_pkg::ROW_IRQ_EN_BIT]) next_pend_row = 1'b0;
  end

  // read data, error and interrupt output
  // prdata keeps its value between reads, so a late master still sees it
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (rd_en) begin
      unique case (paddr)
        srfi_pkg::HV_INTERRUPT_STATUS_ADDR: next_prdata = {24'h000000, status};
        srfi_pkg::IRQ_MASK_ADDR: next_prdata = {30'h00000000, mask};
        srfi_pkg::ROW_COLOR_ATTRIBUTE_ADDR: next_prdata = {24'h000000, row_color_attribute};
        srfi_pkg::PALETTE_SEL_ADDR: next_prdata = {29'h00000000, palette_sel};
        srfi_pkg::DISPLAY_CTRL_ADDR: next_prdata = {30'h00000000, display_ctrl};
        srfi_pkg::ROW_COUNT_ADDR: next_prdata = {25'h0000000, in_field, line_count};
        default: next_prdata = 32'h00000000;
      endcase
    end
    // unmapped access errors in the access phase
    // flagged at the setup edge so it stands while pready is high
    if (psel && !penable && !addr_ok) next_pslverr = 1'b1;
    // irq from field or enabled row
    // mask is the registered value, so a mask write shows one cycle later
    next_irq = (next_status[srfi_pkg::FIELD_FLAG_BIT] & mask[1]) |
               (next_status[srfi_pkg::ROW_FLAG_BIT] & next_status[srfi_pkg::ROW_IRQ_EN_BIT] &
                mask[0]);
    next_row_start = row_event;
    next_field_start = field_event;
  end

  // registers only
  // asynchronous reset loads constants; bus, irq and pulse outputs leave from here, colour outputs from u_color
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status <= srfi_pkg::STATUS_RESET;
      mask <= srfi_pkg::MASK_RESET;
      row_color_attribute <= 8'h00;
      palette_sel <= 3'h0;
      display_ctrl <= 2'h0;
      line_count <= 6'h00;
      in_field <= 1'b0;
      pend_row <= 1'b0;
      pend_field <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0; // no answers while held in reset
      pslverr <= 1'b0;
      irq_out <= 1'b0;
      row_start_out <= 1'b0;
      field_start_out <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      row_color_attribute <= next_row_color_attribute;
      palette_sel <= next_palette_sel;
      display_ctrl <= next_display_ctrl;
      line_count <= next_line_count;
      in_field <= next_in_field;
      pend_row <= next_pend_row;
      pend_field <= next_pend_field;
      prdata <= next_prdata;
      pready <= 1'b1;
      pslverr <= next_pslverr;
      irq_out <= next_irq;
      row_start_out <= next_row_start;
      field_start_out <= next_field_start;
    end
  end
endmodule : srfi_top

/* File: sim/srfi_sync_source.sv */
`timescale 1ns/1ps
// video sync source: vsync, then LINES hsync pulses, field after field
module srfi_sync_source #(
  parameter int LINE = 8,
  parameter int LINES = 40
) (
  input wire logic clock_in,
  input wire logic run_in,
  output logic hsync_out,
  output logic vsync_out
);
  int cnt = 0; // clocks into the field
  // field position, parked at zero while stopped so pins stand still
  always @(posedge clock_in) begin
    if (!run_in || cnt == LINE * (LINES + 4) - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign vsync_out = run_in && cnt >= 2 && cnt < 2 + 3 * LINE;
  // half-line hsync pulses after the vsync gap
  assign hsync_out = run_in && cnt >= 4 * LINE && cnt % LINE < LINE / 2;
endmodule : srfi_sync_source

/* File: sim/srfi_top_asserts.sv */
`timescale 1ns/1ps
// pin level checks of event timing, irq and colour modes
module srfi_top_checker (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic irq_out,
  input wire logic row_start_out,
  input wire logic field_start_out,
  input wire logic use_palette_out,
  input wire logic fringe_on_out
);
  logic wr; // write completing this cycle
  logic [1:0] ctl; // shadow of {progressive, palette mode}
  logic [1:0] next_ctl;
  assign wr = psel && penable && pwrite;
  // follow the mode bits software writes
  always_comb begin
    next_ctl = ctl;
    if (wr && paddr == srfi_pkg::DISPLAY_CTRL_ADDR) begin
      next_ctl[1] = pwdata[srfi_pkg::PROGRESSIVE_BIT];
    end
    if (wr && paddr == srfi_pkg::HV_INTERRUPT_STATUS_ADDR) begin
      next_ctl[0] = pwdata[srfi_pkg::PALETTE_MODE_BIT];
    end
  end
  // shadow register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl <= 2'h0;
    end else begin
      ctl <= next_ctl;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  a_field_follows: assert property ($rose(vsync_in) |-> ##[1:6] field_start_out)
    else $error("no field pulse after vsync");
  a_field_single: assert property (field_start_out |=> !field_start_out)
    else $error("field pulse too long");
  a_field_cause: assert property (field_start_out |-> $past(vsync_in, 2))
    else $error("field pulse without vsync");
  a_row_cause: assert property (row_start_out |-> $past(hsync_in, 2))
    else $error("row pulse without hsync");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(wr) || $past(wr, 2))
    else $error("irq dropped without write");
  a_irq_cause: assert property ($rose(irq_out) |->
    field_start_out || row_start_out || $past(wr) || $past(wr, 2))
    else $error("irq raised without event");
  a_palette_off: assert property (!ctl[0] && !$past(ctl[0]) |-> !use_palette_out)
    else $error("palette used in normal mode");
  a_fringe_prog: assert property (ctl[1] && $past(ctl[1]) |-> !fringe_on_out)
    else $error("fringe in progressive mode");
  c_field: cover property (field_start_out && irq_out);
  c_row: cover property (row_start_out);
  c_clear: cover property ($fell(irq_out));
endmodule : srfi_top_checker
bind srfi_top srfi_top_checker u_chk (.*);

/* File: sim/test_sync_row_field_interrupt.sv */
`timescale 1ns/1ps
// apb register traffic against a sync source model
module test_sync_row_field_interrupt;
  localparam int LINE = 8; // clocks per scan line
  localparam int FIELD = LINE * 44; // 40 lines plus vsync gap
  localparam logic [9:0] ST = srfi_pkg::HV_INTERRUPT_STATUS_ADDR;
  localparam logic [9:0] MK = srfi_pkg::IRQ_MASK_ADDR;
  localparam logic [9:0] DC = srfi_pkg::DISPLAY_CTRL_ADDR;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic run = 1'b0; // sync source running
  logic hsync_in, vsync_in, pready, pslverr, irq_out, row_start_out, field_start_out;
  logic use_palette_out, fg_on_out, bg_on_out, fringe_on_out, err;
  logic [2:0] fg_rgb_out, bg_rgb_out, fringe_color_out;
  logic [31:0] prdata, rd;
  logic [12:0] colr; // whole colour path in one word
  int mismatches = 0;
  int check_count = 0;
  int n;
  assign colr = {use_palette_out, fg_on_out, fg_rgb_out, bg_on_out, bg_rgb_out,
    fringe_on_out, fringe_color_out};
  srfi_top DUT (.*);
  srfi_sync_source #(.LINE(LINE), .LINES(40)) src (.clock_in, .run_in(run),
    .hsync_out(hsync_in), .vsync_out(vsync_in));
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask : apb
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  // wait for a row (1) or field (0) pulse, counting clocks
  task automatic wait_ev(input logic row, output int c);
    c = 0;
    do begin
      @(posedge clock_in);
      c++;
    end while ((row ? row_start_out : field_start_out) !== 1'b1 && c < 1000);
  endtask : wait_ev
  // program the colour path; outputs trail by a cycle
  task automatic col(input logic [7:0] at, input logic [2:0] sel, input logic [7:0] st,
      input logic [1:0] dc);
    apb(1'b1, srfi_pkg::ROW_COLOR_ATTRIBUTE_ADDR, {24'h0, at});
    apb(1'b1, srfi_pkg::PALETTE_SEL_ADDR, {29'h0, sel});
    apb(1'b1, DC, {30'h0, dc});
    apb(1'b1, ST, {24'h0, st});
    @(posedge clock_in);
  endtask : col
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // hang guard, far beyond the expected run
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    rdchk(ST, {24'h0, srfi_pkg::STATUS_RESET});
    rdchk(MK, {30'h0, srfi_pkg::MASK_RESET});
    rdchk(10'h03c, 32'h0);
    chk(err, 1'b1);
    chk(pready, 1'b1);
    rdchk(srfi_pkg::ROW_COUNT_ADDR, 32'h0);
    apb(1'b1, ST, 32'hfc);
    rdchk(ST, 32'hfc);
    col(8'h3d, 3'h0, 8'h00, 2'h0);
    chk(colr, 13'b0_1_011_1_101_1_101);
    col(8'hb5, 3'h0, 8'he0, 2'h0);
    chk(colr, 13'b0_0_011_0_101_1_110);
    col(8'h3d, 3'h0, 8'h08, 2'h0);
    chk(colr, 13'b0_1_011_1_101_1_101);
    col(8'h3d, 3'h2, 8'h08, 2'h0);
    chk(use_palette_out, 1'b1);
    col(8'h3d, 3'h0, 8'he0, 2'h2);
    chk(fringe_on_out, 1'b0);
    col(8'h3d, 3'h0, 8'h07, 2'h0);
    run <= 1'b1;
    wait_ev(1'b0, n);
    wait_ev(1'b1, n);
    rdchk(ST, 32'h06);
    chk(irq_out, 1'b1);
    apb(1'b1, ST, 32'h06);
    rdchk(ST, 32'h05);
    apb(1'b1, ST, 32'h04);
    rdchk(ST, 32'h05);
    apb(1'b1, ST, 32'h05);
    rdchk(ST, 32'h04);
    chk(irq_out, 1'b0);
    wait_ev(1'b1, n);
    wait_ev(1'b1, n);
    chk(n, srfi_pkg::LINES_NORMAL * LINE);
    apb(1'b1, DC, 32'h1);
    wait_ev(1'b0, n);
    wait_ev(1'b1, n);
    wait_ev(1'b1, n);
    chk(n, srfi_pkg::LINES_DOUBLE * LINE);
    rdchk(ST, 32'h05);
    apb(1'b1, DC, 32'h0);
    apb(1'b1, ST, 32'h03);
    rdchk(ST, 32'h02);
    wait_ev(1'b0, n);
    wait_ev(1'b0, n);
    chk(n, FIELD);
    rdchk(ST, 32'h02);
    apb(1'b1, MK, 32'h1);
    @(posedge clock_in);
    chk(irq_out, 1'b0);
    apb(1'b1, MK, 32'h3);
    @(posedge clock_in);
    chk(irq_out, 1'b1);
    conclude();
  end
endmodule : test_sync_row_field_interrupt
